// [verilog/sfb_pkg.sv]
package sfb_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_SYS_EN = 8'h04;
    localparam logic [7:0] IDX_SUP_EN = 8'h1C;
    localparam logic [7:0] IDX_SUMMARY = 8'h60;
    localparam logic [7:0] IDX_SYS_STAT = 8'h61;
    localparam logic [7:0] IDX_SUP_STAT = 8'h62;
    localparam logic [7:0] IDX_P14_FLT = 8'h65;
    localparam logic [7:0] IDX_P58_EDGE = 8'h66;
    localparam logic [7:0] IDX_P58_FLT = 8'h67;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h6F;

    // System enable and status fields
    localparam int SYS_OTW_BIT = 2;
    localparam int SYS_SPIF_BIT = 1;
    localparam logic [7:0] SYS_MASK = 8'h06;

    // Supply enable and status fields
    localparam int SUP_CONV_BIT = 5;
    localparam logic [7:0] SUP_MASK = 8'h3F;

    // Summary fields, also the layout of the interrupt mask
    localparam int SUM_SYS_BIT = 0;
    localparam int SUM_SUP_BIT = 1;
    localparam int SUM_P14F_BIT = 4;
    localparam int SUM_P58E_BIT = 5;
    localparam int SUM_P58F_BIT = 6;
    localparam logic [7:0] SUM_MASK = 8'h73;

    // Reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // Bus answer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } sfb_apb_st_t;

    // One-cycle event pulses from the sources
    typedef struct packed {
        logic [7:0] pin14_fault;
        logic [7:0] pin58_edge;
        logic [7:0] pin58_fault;
        logic [1:0] sys;
        logic [4:0] sup;
    } sfb_evt_t;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] sfb_byte_addr(
        input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : sfb_byte_addr

endpackage : sfb_pkg

// [verilog/sfb_interrupt_flag_bank.sv]
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module sfb_interrupt_flag_bank
    import sfb_pkg::*;
#(
    parameter int HAS_PINS_1_TO_4 = 1,
    parameter int HAS_PINS_5_TO_8 = 1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sfb_evt_t evt,
    input wire logic converter_state_bit,
    output logic irq
);

    // Refuse bank options other than present or absent
    generate
        if (HAS_PINS_1_TO_4 < 0 || HAS_PINS_1_TO_4 > 1 ||
            HAS_PINS_5_TO_8 < 0 || HAS_PINS_5_TO_8 > 1) begin : g_bad
            $error("bank option must be 0 or 1");
        end
    endgenerate

    localparam bit BANK1 = (HAS_PINS_1_TO_4 == 1);
    localparam bit BANK2 = (HAS_PINS_5_TO_8 == 1);

    sfb_apb_st_t st_r, st_nxt;
    logic [DATA_W-1:0] prdata_r, prdata_nxt;
    logic [7:0] sys_en_r, sys_en_nxt;
    logic [7:0] sup_en_r, sup_en_nxt;
    logic [7:0] irq_mask_r, irq_mask_nxt;
    logic [7:0] sys_stat_r, sys_stat_nxt;
    logic [7:0] sup_stat_r, sup_stat_nxt;
    logic [7:0] p14_r, p14_nxt;
    logic [7:0] p58e_r, p58e_nxt;
    logic [7:0] p58f_r, p58f_nxt;
    logic conv_prev_r, conv_prev_nxt;
    logic conv_seen_r, conv_seen_nxt;
    logic irq_r, irq_nxt;
    logic hit;
    logic [7:0] rd_val;
    logic [7:0] sum;
    logic wr_acc;
    logic conv_change;
    logic [7:0] sys_set, sup_set;

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_val = 8'h00;
        case (paddr)
            sfb_byte_addr(IDX_SYS_EN): rd_val = sys_en_r;
            sfb_byte_addr(IDX_SUP_EN): rd_val = sup_en_r;
            sfb_byte_addr(IDX_SUMMARY): rd_val = sum;
            sfb_byte_addr(IDX_SYS_STAT): rd_val = sys_stat_r;
            sfb_byte_addr(IDX_SUP_STAT): rd_val = sup_stat_r;
            sfb_byte_addr(IDX_IRQ_MASK): rd_val = irq_mask_r;
            sfb_byte_addr(IDX_P14_FLT): begin
                hit = BANK1;
                rd_val = p14_r;
            end
            sfb_byte_addr(IDX_P58_EDGE): begin
                hit = BANK2;
                rd_val = p58e_r;
            end
            sfb_byte_addr(IDX_P58_FLT): begin
                hit = BANK2;
                rd_val = p58f_r;
            end
            default: hit = 1'b0;
        endcase
    end

    // Handshake: one wait cycle, then ready
    assign pready = ce && (st_r == ST_ACK);
    assign pslverr = pready && !hit;
    assign prdata = prdata_r;
    assign irq = irq_r;
    assign wr_acc = ce && psel && penable && pwrite && pready && hit;

    // Summary, counting system and supply flags only where enabled
    always_comb begin
        sum = 8'h00;
        sum[SUM_SYS_BIT] = |(sys_stat_r & sys_en_r);
        sum[SUM_SUP_BIT] = |(sup_stat_r & sup_en_r);
        sum[SUM_P14F_BIT] = |p14_r;
        sum[SUM_P58E_BIT] = |p58e_r;
        sum[SUM_P58F_BIT] = |p58f_r;
    end

    // Source events gated by their enables
    always_comb begin
        conv_change = conv_seen_r
            && (converter_state_bit != conv_prev_r);
        sys_set = 8'h00;
        sys_set[SYS_OTW_BIT] = evt.sys[1];
        sys_set[SYS_SPIF_BIT] = evt.sys[0];
        sys_set = sys_set & sys_en_r;
        sup_set = {2'b00, conv_change, evt.sup} & sup_en_r;
    end

    // Next state of bus answer and all registers
    always_comb begin
        st_nxt = st_r;
        prdata_nxt = prdata_r;
        sys_en_nxt = sys_en_r;
        sup_en_nxt = sup_en_r;
        irq_mask_nxt = irq_mask_r;
        sys_stat_nxt = sys_stat_r;
        sup_stat_nxt = sup_stat_r;
        p14_nxt = p14_r;
        p58e_nxt = p58e_r;
        p58f_nxt = p58f_r;
        conv_prev_nxt = conv_prev_r;
        conv_seen_nxt = conv_seen_r;
        irq_nxt = irq_r;
        if (ce) begin
            case (st_r)
                ST_IDLE: begin
                    if (psel && penable) begin
                        st_nxt = ST_ACK;
                        prdata_nxt = pwrite ? '0 : {24'h000000, rd_val};
                    end
                end
                ST_ACK: st_nxt = ST_IDLE;
                default: st_nxt = ST_IDLE;
            endcase
            conv_prev_nxt = converter_state_bit;
            conv_seen_nxt = 1'b1;
            // Write-one-to-clear first, then sets win over clears
            if (wr_acc) begin
                case (paddr)
                    sfb_byte_addr(IDX_SYS_EN):
                        sys_en_nxt = pwdata[7:0] & SYS_MASK;
                    sfb_byte_addr(IDX_SUP_EN):
                        sup_en_nxt = pwdata[7:0] & SUP_MASK;
                    sfb_byte_addr(IDX_IRQ_MASK):
                        irq_mask_nxt = pwdata[7:0] & SUM_MASK;
                    sfb_byte_addr(IDX_SYS_STAT):
                        sys_stat_nxt = sys_stat_r & ~pwdata[7:0];
                    sfb_byte_addr(IDX_SUP_STAT):
                        sup_stat_nxt = sup_stat_r & ~pwdata[7:0];
                    sfb_byte_addr(IDX_P14_FLT):
                        p14_nxt = p14_r & ~pwdata[7:0];
                    sfb_byte_addr(IDX_P58_EDGE):
                        p58e_nxt = p58e_r & ~pwdata[7:0];
                    sfb_byte_addr(IDX_P58_FLT):
                        p58f_nxt = p58f_r & ~pwdata[7:0];
                    default: ;
                endcase
            end
            sys_stat_nxt = (sys_stat_nxt | sys_set) & SYS_MASK;
            sup_stat_nxt = (sup_stat_nxt | sup_set) & SUP_MASK;
            p14_nxt = BANK1 ? (p14_nxt | evt.pin14_fault)
                : 8'h00;
            p58e_nxt = BANK2 ? (p58e_nxt | evt.pin58_edge)
                : 8'h00;
            p58f_nxt = BANK2 ? (p58f_nxt | evt.pin58_fault)
                : 8'h00;
            irq_nxt = |(sum & irq_mask_r);
        end
    end

    // Register stage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
            prdata_r <= '0;
            sys_en_r <= RST_ENABLE;
            sup_en_r <= RST_ENABLE;
            irq_mask_r <= RST_IRQ_MASK;
            sys_stat_r <= RST_FLAGS;
            sup_stat_r <= RST_FLAGS;
            p14_r <= RST_FLAGS;
            p58e_r <= RST_FLAGS;
            p58f_r <= RST_FLAGS;
            conv_prev_r <= 1'b0;
            conv_seen_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            prdata_r <= prdata_nxt;
            sys_en_r <= sys_en_nxt;
            sup_en_r <= sup_en_nxt;
            irq_mask_r <= irq_mask_nxt;
            sys_stat_r <= sys_stat_nxt;
            sup_stat_r <= sup_stat_nxt;
            p14_r <= p14_nxt;
            p58e_r <= p58e_nxt;
            p58f_r <= p58f_nxt;
            conv_prev_r <= conv_prev_nxt;
            conv_seen_r <= conv_seen_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_access;
        ce && psel && penable && st_r == ST_IDLE;
    endsequence

    sequence s_read_sys_en;
        s_access ##0 (!pwrite && paddr == sfb_byte_addr(IDX_SYS_EN));
    endsequence

    sequence s_read_summary;
        s_access ##0 (!pwrite && paddr == sfb_byte_addr(IDX_SUMMARY));
    endsequence

    sequence s_read_p58f;
        s_access ##0 (!pwrite && paddr == sfb_byte_addr(IDX_P58_FLT));
    endsequence

    a_ready_one_wait: assert property (
        s_access |=> pready ##1 !pready)
        else $error("ready not one cycle after access start");

    a_read_enable_data: assert property (
        s_read_sys_en |=> prdata[7:0] == $past(sys_en_r))
        else $error("enable read data wrong");

    a_enable_reserved: assert property (
        (sys_en_r & ~SYS_MASK) == 8'h00 && (sup_en_r & ~SUP_MASK) == 8'h00)
        else $error("reserved enable bit set");

    a_pin_flag_clear: assert property (
        wr_acc && paddr == sfb_byte_addr(IDX_P14_FLT) && pwdata[0]
        && !evt.pin14_fault[0] |=> !p14_r[0])
        else $error("write one did not clear flag");

    a_set_wins_clear: assert property (
        ce && BANK2 && evt.pin58_edge[7] |=> p58e_r[7])
        else $error("edge event lost");

    a_conv_change_flag: assert property (
        ce && conv_change && sup_en_r[SUP_CONV_BIT]
        |=> sup_stat_r[SUP_CONV_BIT])
        else $error("converter change not flagged");

    a_disabled_no_flag: assert property (
        !sys_en_r[SYS_OTW_BIT] && !sys_stat_r[SYS_OTW_BIT]
        |=> !sys_stat_r[SYS_OTW_BIT])
        else $error("disabled source set a flag");

    a_summary_fault: assert property (
        s_read_summary |=> prdata[SUM_P58F_BIT] == ($past(p58f_r) != 8'h00))
        else $error("summary disagrees with flags");

    a_absent_bank: assert property (
        !BANK1 && pready && paddr == sfb_byte_addr(IDX_P14_FLT) |-> pslverr)
        else $error("absent register answered");

    a_irq_level: assert property (
        ce && (|(sum & irq_mask_r)) |=> irq)
        else $error("interrupt not raised");

    a_irq_low: assert property (
        ce && !(|(sum & irq_mask_r)) |=> !irq)
        else $error("interrupt not released");

    a_p14_flag_set: assert property (
        ce && BANK1 && evt.pin14_fault != 8'h00
        |=> (p14_r & $past(evt.pin14_fault)) == $past(evt.pin14_fault))
        else $error("pin 1-4 fault event lost");

    a_p58_fault_set: assert property (
        ce && BANK2 && evt.pin58_fault != 8'h00
        |=> (p58f_r & $past(evt.pin58_fault)) == $past(evt.pin58_fault))
        else $error("pin 5-8 fault event lost");

    a_absent_upper: assert property (
        !BANK2 && pready && (paddr == sfb_byte_addr(IDX_P58_EDGE)
        || paddr == sfb_byte_addr(IDX_P58_FLT)) |-> pslverr)
        else $error("absent upper register answered");

    a_p58f_read: assert property (
        s_read_p58f |=> prdata[7:0] == $past(p58f_r))
        else $error("pin 5-8 fault read data wrong");

    a_enabled_sets: assert property (
        ce && sys_en_r[SYS_OTW_BIT] && evt.sys[1]
        |=> sys_stat_r[SYS_OTW_BIT])
        else $error("enabled source not flagged");

    a_stat_reserved: assert property (
        (sys_stat_r & ~SYS_MASK) == 8'h00
        && (sup_stat_r & ~SUP_MASK) == 8'h00)
        else $error("reserved status bit set");

endmodule : sfb_interrupt_flag_bank

// [verif/sfb_host_model.sv]
`timescale 1ns/100ps
// Host microcontroller side: an APB master doing whole transfers
module sfb_host_model
    import sfb_pkg::*;
(
    input wire logic sys_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // Setup, then access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd, output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : sfb_host_model

// [verif/tb_sfb_interrupt_flag_bank.sv]
`timescale 1ns/100ps
// Bench for the flag bank: register traffic, event pulses, interrupt line
module tb_sfb_interrupt_flag_bank;
    import sfb_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic conv = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    sfb_evt_t evt = '0;
    sfb_evt_t ev;
    int num_errors = 0;
    int checks = 0;
    logic [DATA_W-1:0] prdata_nb;
    logic pready_nb, pslverr_nb, err_nb;
    logic [7:0] rd_nb;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    sfb_interrupt_flag_bank u_dut (.sys_clk(sys_clk), .nrst(nrst),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .converter_state_bit(conv),
        .irq(irq));
    sfb_host_model u_host (.sys_clk(sys_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // Variant with both pin banks absent, on the same bus
    sfb_interrupt_flag_bank #(.HAS_PINS_1_TO_4(0), .HAS_PINS_5_TO_8(0))
        u_dut_nb (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata_nb), .pready(pready_nb),
        .pslverr(pslverr_nb), .evt(evt), .converter_state_bit(conv),
        .irq());

    // Capture the bank-less variant's answer at its ready edge
    always @(posedge sys_clk) begin
        if (psel && penable && pready_nb) begin
            err_nb <= pslverr_nb;
            rd_nb <= prdata_nb[7:0];
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rdc(input string n, input logic [7:0] idx,
        input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b0, idx, 8'h00, r, e);
        chk(n, {24'h000000, exp}, r);
    endtask : rdc

    // One-cycle event pulse
    task automatic pulse(input sfb_evt_t e);
        @(posedge sys_clk);
        evt <= e;
        @(posedge sys_clk);
        evt <= '0;
    endtask : pulse

    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge sys_clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask : chk_irq

    // Answer of the bank-less variant to the transfer just done
    task automatic chk_nb(input string n, input logic exp_err,
        input logic [7:0] exp_rd);
        @(posedge sys_clk);
        chk(n, {31'h0, exp_err}, {31'h0, err_nb});
        chk(n, {24'h000000, exp_rd}, {24'h000000, rd_nb});
    endtask : chk_nb

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // Cut a hang short
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        logic e;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        rdc("sys_en", IDX_SYS_EN, RST_ENABLE);
        rdc("sup_en", IDX_SUP_EN, RST_ENABLE);
        rdc("p14_flt", IDX_P14_FLT, RST_FLAGS);
        rdc("p58_edge", IDX_P58_EDGE, RST_FLAGS);
        rdc("p58_flt", IDX_P58_FLT, RST_FLAGS);
        $display("test reset values done");
        wr(IDX_SYS_EN, 8'hFF);
        rdc("sys_en", IDX_SYS_EN, SYS_MASK);
        chk_nb("nb_sys_en", 1'b0, SYS_MASK);
        wr(IDX_SUP_EN, 8'hFF);
        rdc("sup_en", IDX_SUP_EN, SUP_MASK);
        $display("test enable fields done");
        ev = '0;
        ev.pin14_fault = 8'hA5;
        ev.pin58_edge = 8'h3C;
        ev.pin58_fault = 8'h81;
        pulse(ev);
        rdc("p14_flt", IDX_P14_FLT, 8'hA5);
        chk_nb("nb_p14_flt", 1'b1, 8'h00);
        rdc("p58_edge", IDX_P58_EDGE, 8'h3C);
        chk_nb("nb_p58_edge", 1'b1, 8'h00);
        rdc("p58_flt", IDX_P58_FLT, 8'h81);
        chk_nb("nb_p58_flt", 1'b1, 8'h00);
        rdc("summary", IDX_SUMMARY, 8'h70);
        wr(IDX_P14_FLT, 8'h21);
        rdc("p14_flt", IDX_P14_FLT, 8'h84);
        wr(IDX_P58_EDGE, 8'h00);
        rdc("p58_edge", IDX_P58_EDGE, 8'h3C);
        wr(IDX_P14_FLT, 8'hFF);
        wr(IDX_P58_EDGE, 8'hFF);
        wr(IDX_P58_FLT, 8'hFF);
        rdc("summary", IDX_SUMMARY, 8'h00);
        // Event in the very cycle the clear lands: the flag must stay
        ev = '0;
        ev.pin58_edge = 8'h80;
        fork
            wr(IDX_P58_EDGE, 8'h80);
            begin
                repeat (3) @(posedge sys_clk);
                evt <= ev;
                @(posedge sys_clk);
                evt <= '0;
            end
        join
        rdc("p58_edge", IDX_P58_EDGE, 8'h80);
        wr(IDX_P58_EDGE, 8'hFF);
        // An event while the clock enable is low is not taken
        ce <= 1'b0;
        ev = '0;
        ev.pin14_fault = 8'h01;
        pulse(ev);
        ce <= 1'b1;
        rdc("p14_flt_ce", IDX_P14_FLT, 8'h00);
        $display("test pin flags done");
        ev = '0;
        ev.sys = 2'b11;
        ev.sup = 5'h01;
        wr(IDX_SYS_EN, 8'h00);
        wr(IDX_SUP_EN, 8'h00);
        pulse(ev);
        rdc("sys_stat", IDX_SYS_STAT, 8'h00);
        rdc("sup_stat", IDX_SUP_STAT, 8'h00);
        rdc("summary", IDX_SUMMARY, 8'h00);
        wr(IDX_SYS_EN, SYS_MASK);
        ev.sys = 2'b10;
        pulse(ev);
        rdc("sys_stat", IDX_SYS_STAT, 8'h04);
        wr(IDX_SUP_EN, 8'h20);
        @(posedge sys_clk);
        conv <= 1'b1;
        pulse(ev);
        rdc("sup_stat", IDX_SUP_STAT, 8'h20);
        rdc("summary", IDX_SUMMARY, 8'h03);
        wr(IDX_SUP_STAT, 8'h20);
        rdc("sup_stat", IDX_SUP_STAT, 8'h00);
        @(posedge sys_clk);
        conv <= 1'b0;
        rdc("sup_stat", IDX_SUP_STAT, 8'h20);
        $display("test enables and converter done");
        chk_irq(1'b0);
        wr(IDX_IRQ_MASK, 8'h02);
        chk_irq(1'b1);
        wr(IDX_SUP_STAT, 8'hFF);
        chk_irq(1'b0);
        wr(IDX_SUP_EN, 8'h01);
        pulse(ev);
        rdc("sup_stat", IDX_SUP_STAT, 8'h01);
        chk_irq(1'b1);
        $display("test interrupt line done");
        u_host.xfer(1'b0, 8'h3F, 8'h00, r, e);
        chk("unmapped_err", 32'h00000001, {31'h0, e});
        chk("unmapped_data", 32'h00000000, r);
        $display("test unmapped address done");
        give_verdict();
    end
endmodule : tb_sfb_interrupt_flag_bank
